// File: src/pin_mux_pkg.sv
package pin_mux_pkg;
// Notes on behaviour
// - pin 0 feeds routing or analog trigger; as output drives acquisition start trigger.
// - without pretrigger, acquisition start trigger rises at sequence start.
// - with pretrigger, acquisition start trigger rises when pretrigger conversions begin.
// - pin 1 rises at posttrigger start in pretrigger mode only.
// - pin 2 drives active-low conversion strobe; falling edge per conversion.
// - pin 3 drives the source actually selected for counter 1.
// - pin 4 drives the gate actually selected for counter 1.
// - counter 1 output pin carries counter 1 output directly.
// - pin 5 drives active-low update strobe; falling edge per primary update.
// - pin 7 pulses once per scan, rising edge at scan start.
// - enabled conversion clock gives exactly one pulse per conversion.
// - conversion clock rises when sampled input no longer needed.
// - external strobe changes level only on software command.
// - digital lines 6 and 7 steer counter 0 and counter 1 direction.
// - pins 1 to 9 take input when driver off, drive signal when enabled.
// - any pin may source any timing signal except counter 0 source and gate; drivers enabled one by one.

    localparam int unsigned PIN_COUNT = 10;
    localparam int unsigned ROUTE_COUNT = 8;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // source selector code meaning internal source
    localparam logic [3:0] SEL_INTERNAL = 4'hf;

    // register byte offsets
    localparam logic [7:0] OFF_PIN_DRIVE = 8'h00;
    localparam logic [7:0] OFF_MISC = 8'h04;
    localparam logic [7:0] OFF_SOURCE_SEL = 8'h08;
    localparam logic [7:0] OFF_PIN_STATUS = 8'h0c;

    // field positions
    localparam int unsigned MISC_CONV_CLK_EN_BIT = 0;
    localparam int unsigned MISC_STROBE_BIT = 1;
    localparam int unsigned STATUS_DIR_LSB = 16;
    localparam int unsigned STATUS_CONV_CLK_BIT = 20;

    // reset values
    localparam logic [9:0] RST_PIN_DRIVE = 10'h000;
    localparam logic [1:0] RST_MISC = 2'h2;
    localparam logic [31:0] RST_SOURCE_SEL = 32'hffffffff;

    // route slots; slots 0..7 share the index of their output pin
    localparam int unsigned ROUTE_ACQ = 0;
    localparam int unsigned ROUTE_POST = 1;
    localparam int unsigned ROUTE_CONVERT = 2;
    localparam int unsigned ROUTE_CTR1_SRC = 3;
    localparam int unsigned ROUTE_CTR1_GATE = 4;
    localparam int unsigned ROUTE_UPDATE = 5;
    localparam int unsigned ROUTE_WAVE = 6;
    localparam int unsigned ROUTE_SCAN = 7;
    localparam int unsigned PIN_CTR0_SRC = 8;
    localparam int unsigned PIN_CTR0_GATE = 9;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned PULSE_NS = 80;
    localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pin_mux_pkg

// File: src/pulse_stretch.sv
`timescale 1ns/1ps
module pulse_stretch #(
    parameter int unsigned CYCLES = 2,
    parameter bit IDLE_LEVEL = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // event in, shaped level out
    input wire logic fire_i,
    output logic level_o
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_level;

    if (CYCLES < 1 || CYCLES > 255) begin : g_check
        $error("pulse_stretch: CYCLES out of range");
    end

    // a new event restarts the pulse
    always_comb begin
        if (fire_i) begin
            next_count = 8'(CYCLES);
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end else begin
            next_count = 8'h00;
        end
        next_level = (next_count != 8'h00) ? ~IDLE_LEVEL : IDLE_LEVEL;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 8'h00;
            level_o <= IDLE_LEVEL;
        end else if (ce_i) begin
            count <= next_count;
            level_o <= next_level;
        end
    end
endmodule : pulse_stretch

// File: src/timing_signal_connector_pins.sv
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module timing_signal_connector_pins
    import pin_mux_pkg::*;
#(
    parameter int unsigned STROBE_CYCLES = pin_mux_pkg::PULSE_CYC
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pin_mux_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [pin_mux_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // function pins
    input wire logic [pin_mux_pkg::PIN_COUNT-1:0] function_pin_i,
    output logic [pin_mux_pkg::PIN_COUNT-1:0] function_pin_o,
    output logic [pin_mux_pkg::PIN_COUNT-1:0] function_pin_oe_o,
    // digital lines 6 and 7
    input wire logic [7:6] digital_line_i,
    // fixed connector outputs
    output logic counter1_output_o,
    output logic conversion_clock_out_o,
    output logic conversion_clock_oe_o,
    output logic external_strobe_n_o,
    // timing engine events
    input wire logic acq_begin_i,
    input wire logic post_begin_i,
    input wire logic pretrigger_mode_i,
    input wire logic convert_i,
    input wire logic sample_done_i,
    input wire logic update_i,
    input wire logic waveform_begin_i,
    input wire logic scan_begin_i,
    // counter signals from the engine
    input wire logic counter1_source_i,
    input wire logic counter1_gate_i,
    input wire logic counter1_out_i,
    input wire logic counter0_source_i,
    input wire logic counter0_gate_i,
    // routed inputs to the engine
    output logic [pin_mux_pkg::ROUTE_COUNT-1:0] route_ext_o,
    output logic [pin_mux_pkg::ROUTE_COUNT-1:0] route_ext_sel_o,
    output logic analog_trig_src_o,
    output logic counter0_up_o,
    output logic counter1_up_o
);
    import pin_mux_pkg::*;

    if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin : g_check
        $error("timing_signal_connector_pins: STROBE_CYCLES out of range");
    end

    // selector that names a real pin
    function automatic logic sel_is_pin(input logic [3:0] sel);
        sel_is_pin = (sel < 4'(PIN_COUNT));
    endfunction : sel_is_pin

    // level of the pin a selector names, low if none
    function automatic logic pin_pick(input logic [PIN_COUNT-1:0] pins, input logic [3:0] sel);
        pin_pick = 1'b0;
        for (int unsigned i = 0; i < PIN_COUNT; i++) begin
            if (sel == 4'(i)) begin
                pin_pick = pins[i];
            end
        end
    endfunction : pin_pick

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                          input logic [3:0] strb);
        merge = old;
        for (int unsigned b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
    endfunction : merge

    // ---------------- input synchronisers ----------------
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [7:6] dio_meta;
    logic [7:6] dio_sync;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
            dio_meta <= '0;
            dio_sync <= '0;
        end else if (ce_i) begin
            pin_meta <= function_pin_i;
            pin_sync <= pin_meta;
            dio_meta <= digital_line_i;
            dio_sync <= dio_meta;
        end
    end

    assign analog_trig_src_o = pin_sync[0];
    assign counter0_up_o = dio_sync[6];
    assign counter1_up_o = dio_sync[7];

    // ---------------- registers and apb ----------------
    logic [PIN_COUNT-1:0] pin_drive;
    logic [1:0] misc;
    logic [31:0] source_sel;
    logic conv_clk;
    logic [PIN_COUNT-1:0] next_pin_drive;
    logic [1:0] next_misc;
    logic [31:0] next_source_sel;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] rd_word;
    logic hit;
    logic commit;
    logic [31:0] wr_word;

    always_comb begin
        hit = 1'b1;
        case (paddr_i)
            OFF_PIN_DRIVE: rd_word = {22'h0, pin_drive};
            OFF_MISC: rd_word = {30'h0, misc};
            OFF_SOURCE_SEL: rd_word = source_sel;
            OFF_PIN_STATUS: begin
                rd_word = {22'h0, pin_sync};
                rd_word[STATUS_DIR_LSB +: 2] = dio_sync;
                rd_word[STATUS_CONV_CLK_BIT] = conv_clk;
            end
            default: begin
                rd_word = 32'h0;
                hit = 1'b0;
            end
        endcase
        // one wait cycle: answer prepared in the first access cycle
        next_pready = psel_i & penable_i & ~pready_o;
        next_prdata = next_pready ? rd_word : 32'h0;
        next_pslverr = next_pready & ~hit;
        commit = psel_i & penable_i & pready_o & pwrite_i;
        wr_word = merge(rd_word, pwdata_i, pstrb_i);
        next_pin_drive = pin_drive;
        next_misc = misc;
        next_source_sel = source_sel;
        if (commit) begin
            case (paddr_i)
                OFF_PIN_DRIVE: next_pin_drive = wr_word[PIN_COUNT-1:0];
                OFF_MISC: next_misc = wr_word[1:0];
                OFF_SOURCE_SEL: next_source_sel = wr_word;
                default: next_misc = misc;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_drive <= RST_PIN_DRIVE;
            misc <= RST_MISC;
            source_sel <= RST_SOURCE_SEL;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pin_drive <= next_pin_drive;
            misc <= next_misc;
            source_sel <= next_source_sel;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // ---------------- routing to the engine ----------------
    logic [ROUTE_COUNT-1:0] next_route_ext;
    logic [ROUTE_COUNT-1:0] next_route_sel;

    always_comb begin
        for (int unsigned k = 0; k < ROUTE_COUNT; k++) begin
            next_route_ext[k] = pin_pick(pin_sync, source_sel[k*SEL_W +: SEL_W]);
            next_route_sel[k] = sel_is_pin(source_sel[k*SEL_W +: SEL_W]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_ext_o <= '0;
            route_ext_sel_o <= '0;
        end else if (ce_i) begin
            route_ext_o <= next_route_ext;
            route_ext_sel_o <= next_route_sel;
        end
    end

    // ---------------- shaped timing strobes ----------------
    logic acq_level;
    logic post_level;
    logic convert_n_level;
    logic update_n_level;
    logic wave_level;
    logic scan_level;

    // start of sequence or of pretrigger conversions
    pulse_stretch #(.CYCLES(STROBE_CYCLES), .IDLE_LEVEL(1'b0)) u_acq (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fire_i(acq_begin_i), .level_o(acq_level));
    pulse_stretch #(.CYCLES(STROBE_CYCLES), .IDLE_LEVEL(1'b0)) u_post (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fire_i(post_begin_i & pretrigger_mode_i),
        .level_o(post_level));
    pulse_stretch #(.CYCLES(STROBE_CYCLES), .IDLE_LEVEL(1'b1)) u_convert (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fire_i(convert_i), .level_o(convert_n_level));
    pulse_stretch #(.CYCLES(STROBE_CYCLES), .IDLE_LEVEL(1'b1)) u_update (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fire_i(update_i), .level_o(update_n_level));
    pulse_stretch #(.CYCLES(STROBE_CYCLES), .IDLE_LEVEL(1'b0)) u_wave (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fire_i(waveform_begin_i), .level_o(wave_level));
    pulse_stretch #(.CYCLES(STROBE_CYCLES), .IDLE_LEVEL(1'b0)) u_scan (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fire_i(scan_begin_i), .level_o(scan_level));

    // ---------------- connector pin drive ----------------
    logic [PIN_COUNT-1:0] next_pin_o;
    logic next_conv_clk;
    logic ctr1_src_mirror;
    logic ctr1_gate_mirror;

    always_comb begin
        ctr1_src_mirror = route_ext_sel_o[ROUTE_CTR1_SRC] ? route_ext_o[ROUTE_CTR1_SRC]
                                                           : counter1_source_i;
        ctr1_gate_mirror = route_ext_sel_o[ROUTE_CTR1_GATE] ? route_ext_o[ROUTE_CTR1_GATE]
                                                             : counter1_gate_i;
        next_pin_o = '0;
        next_pin_o[ROUTE_ACQ] = acq_level;
        next_pin_o[ROUTE_POST] = post_level;
        next_pin_o[ROUTE_CONVERT] = convert_n_level;
        next_pin_o[ROUTE_CTR1_SRC] = ctr1_src_mirror;
        next_pin_o[ROUTE_CTR1_GATE] = ctr1_gate_mirror;
        next_pin_o[ROUTE_UPDATE] = update_n_level;
        next_pin_o[ROUTE_WAVE] = wave_level;
        next_pin_o[ROUTE_SCAN] = scan_level;
        next_pin_o[PIN_CTR0_SRC] = counter0_source_i;
        next_pin_o[PIN_CTR0_GATE] = counter0_gate_i;
        // low at conversion, high once sample released
        if (!misc[MISC_CONV_CLK_EN_BIT]) begin
            next_conv_clk = 1'b1;
        end else if (sample_done_i) begin
            next_conv_clk = 1'b1;
        end else if (convert_i) begin
            next_conv_clk = 1'b0;
        end else begin
            next_conv_clk = conv_clk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            function_pin_o <= '0;
            function_pin_oe_o <= '0;
            conv_clk <= 1'b1;
            conversion_clock_oe_o <= 1'b0;
            external_strobe_n_o <= RST_MISC[MISC_STROBE_BIT];
            counter1_output_o <= 1'b0;
        end else if (ce_i) begin
            function_pin_o <= next_pin_o;
            // driver off means pin is an input
            function_pin_oe_o <= pin_drive;
            conv_clk <= next_conv_clk;
            conversion_clock_oe_o <= misc[MISC_CONV_CLK_EN_BIT];
            external_strobe_n_o <= misc[MISC_STROBE_BIT];
            counter1_output_o <= counter1_out_i;
        end
    end

    assign conversion_clock_out_o = conv_clk;

endmodule : timing_signal_connector_pins

// File: bench/pin_mux_props.sv
`timescale 1ns/1ps
module pin_mux_props #(
    parameter int unsigned STROBE_CYCLES = 2
) (
    // clock and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    // pins and lines
    input wire logic [pin_mux_pkg::PIN_COUNT-1:0] function_pin_o,
    input wire logic [pin_mux_pkg::PIN_COUNT-1:0] function_pin_oe_o,
    input wire logic [7:6] digital_line_i,
    input wire logic conversion_clock_out_o,
    input wire logic conversion_clock_oe_o,
    input wire logic external_strobe_n_o,
    input wire logic counter1_up_o,
    // engine events
    input wire logic acq_begin_i,
    input wire logic post_begin_i,
    input wire logic pretrigger_mode_i,
    input wire logic convert_i,
    input wire logic sample_done_i,
    input wire logic update_i,
    input wire logic scan_begin_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire wr = psel_i && penable_i && pwrite_i && pready_o;
    sequence s_scan;
        scan_begin_i && function_pin_oe_o[7] ##1 !scan_begin_i [*3];
    endsequence
    sequence s_pulse;
        $past(function_pin_o[7]) && function_pin_o[7] ##1 !function_pin_o[7];
    endsequence
    property p_oe_reset; $past(rst_i) |-> function_pin_oe_o == '0 && !conversion_clock_oe_o; endproperty
    property p_acq; acq_begin_i && function_pin_oe_o[0] |-> ##2 function_pin_o[0]; endproperty
    property p_post; post_begin_i && pretrigger_mode_i && function_pin_oe_o[1] |-> ##2 function_pin_o[1]; endproperty
    property p_conv; convert_i && function_pin_oe_o[2] |-> ##2 !function_pin_o[2]; endproperty
    property p_update; update_i && function_pin_oe_o[5] |-> ##2 !function_pin_o[5]; endproperty
    property p_scan; s_scan |-> s_pulse; endproperty
    property p_cclk_lo; convert_i && !sample_done_i && conversion_clock_oe_o |=> !conversion_clock_out_o; endproperty
    property p_cclk_hi; sample_done_i |=> conversion_clock_out_o; endproperty
    property p_strobe; $changed(external_strobe_n_o) |-> $past(wr, 2); endproperty
    property p_oe_wr; $changed(function_pin_oe_o) |-> $past(wr, 2); endproperty
    property p_dir; digital_line_i[7] [*5] |-> counter1_up_o; endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("driver on after reset");
    a_acq: assert property (p_acq) else $error("acq start late");
    a_post: assert property (p_post) else $error("post start late");
    a_conv: assert property (p_conv) else $error("convert strobe late");
    a_update: assert property (p_update) else $error("update strobe late");
    a_scan: assert property (p_scan) else $error("scan pulse shape");
    a_cclk_lo: assert property (p_cclk_lo) else $error("conv clock not low");
    a_cclk_hi: assert property (p_cclk_hi) else $error("conv clock not high");
    a_strobe: assert property (p_strobe) else $error("strobe moved alone");
    a_oe_wr: assert property (p_oe_wr) else $error("enable moved alone");
    a_dir: assert property (p_dir) else $error("direction not followed");
endmodule : pin_mux_props
bind timing_signal_connector_pins pin_mux_props #(.STROBE_CYCLES(STROBE_CYCLES)) u_props (.*);

// File: bench/connector_partner.sv
`timescale 1ns/1ps
module connector_partner (
    // device side
    input wire logic clk_i,
    input wire logic [9:0] pin_o_i,
    input wire logic [9:0] pin_oe_i,
    input wire logic conv_clk_i,
    // commanded drive
    input wire logic [9:0] ext_drive_i,
    input wire logic [9:0] ext_en_i,
    // wire levels and count of conversion clock rising edges
    output logic [9:0] wire_o,
    output int switches_o = 0
);
    logic [9:0] float_q = '0;
    logic prev_clk = 1'b1;
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            wire_o[k] = pin_oe_i[k] ? pin_o_i[k] : (ext_en_i[k] ? ext_drive_i[k] : float_q[k]);
        end
    end
    always @(posedge clk_i) begin
        float_q <= ~float_q;
        prev_clk <= conv_clk_i;
        if (conv_clk_i && !prev_clk)
            switches_o <= switches_o + 1;
    end
endmodule : connector_partner

// File: bench/timing_signal_connector_pins_tb.sv
`timescale 1ns/1ps
module timing_signal_connector_pins_tb;
    import pin_mux_pkg::*;
    typedef struct packed {logic err; logic rd; logic [31:0] d;} note_t;
    logic clk_i = 0, rst_i = 1, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
    logic [7:0] paddr_i = '0, ev = '0, route_ext_o, route_ext_sel_o;
    logic [31:0] pwdata_i = '0, prdata_o;
    logic [3:0] pstrb_i = 4'hf;
    logic [9:0] function_pin_i, function_pin_o, function_pin_oe_o, ext_drive = '0, ext_en = '0;
    logic [7:6] digital_line_i = '0;
    logic counter1_output_o, conversion_clock_out_o, conversion_clock_oe_o, external_strobe_n_o;
    logic pretrigger_mode_i = 1, sample_done_i = 0, counter1_source_i = 0, counter1_gate_i = 0;
    logic counter1_out_i = 0, counter0_source_i = 0, counter0_gate_i = 0, src, lvl;
    logic analog_trig_src_o, counter0_up_o, counter1_up_o;
    wire acq_begin_i = ev[0], post_begin_i = ev[1], convert_i = ev[2];
    wire update_i = ev[5], waveform_begin_i = ev[6], scan_begin_i = ev[7];
    note_t notes[$];
    note_t cur;
    int fail_count = 0, comparisons = 0, cycles = 0, switches, base, n;
    int pins[6] = '{0, 1, 2, 5, 6, 7};
    integer seed = 32'h0486;
    timing_signal_connector_pins dut (.*);
    connector_partner u_far (.clk_i, .pin_o_i(function_pin_o), .pin_oe_i(function_pin_oe_o),
        .conv_clk_i(conversion_clock_out_o), .ext_drive_i(ext_drive), .ext_en_i(ext_en),
        .wire_o(function_pin_i), .switches_o(switches));
    initial forever #20 clk_i = ~clk_i;
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic check_sig(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_sig
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask : wait_cyc
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
        input logic err);
        notes.push_back('{err, !w, e});
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        psel_i <= 1'b1;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // idle edge so the next setup never re-raises psel in the same step
        @(posedge clk_i);
    endtask : apb
    task automatic fire(input int k);
        ev[k] <= 1'b1;
        @(posedge clk_i);
        ev[k] <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : fire
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            cur = notes.pop_front();
            check_sig("pslverr", cur.err, pslverr_o);
            if (cur.rd) check_sig("prdata", cur.d, prdata_o);
        end
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        wait_cyc(20);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check_sig("reset pins", 32'h1, {function_pin_oe_o, conversion_clock_oe_o, external_strobe_n_o});
        @(posedge clk_i);
        apb(OFF_PIN_DRIVE, 0, 0, 0, 0);
        apb(OFF_MISC, 0, 0, 2, 0);
        apb(OFF_SOURCE_SEL, 0, 0, 32'hffffffff, 0);
        apb(8'h10, 0, 0, 0, 1);
        apb(OFF_PIN_STATUS, 1, 32'hffffffff, 0, 0);
        apb(OFF_PIN_DRIVE, 1, 32'h3ff, 0, 0);
        apb(OFF_MISC, 1, 32'h1, 0, 0);
        wait_cyc(2);
        check_sig("enables", 32'hffe, {function_pin_oe_o, conversion_clock_oe_o, external_strobe_n_o});
        $display("test registers done");
        foreach (pins[i]) begin
            lvl = pins[i] != 2 && pins[i] != 5;
            fire(pins[i]);
            check_sig("strobe pin", lvl, function_pin_o[pins[i]]);
            wait_cyc(3);
            check_sig("strobe idle", !lvl, function_pin_o[pins[i]]);
        end
        pretrigger_mode_i <= 1'b0;
        fire(1);
        check_sig("post refused", 0, function_pin_o[1]);
        wait_cyc(3);
        n = 3 + ($random(seed) & 3);
        base = switches;
        repeat (n) begin
            fire(2);
            check_sig("conv clock low", 0, conversion_clock_out_o);
            @(posedge clk_i);
            sample_done_i <= 1'b1;
            @(posedge clk_i);
            sample_done_i <= 1'b0;
            wait_cyc(($random(seed) & 3) + 2);
        end
        check_sig("conv clock pulses", n, switches - base);
        $display("test strobes done");
        for (int j = 0; j < 8; j++) begin
            if (j == 4) apb(OFF_SOURCE_SEL, 1, 32'hfff99fff, 0, 0);
            counter1_source_i <= 1'($random(seed));
            counter1_gate_i <= 1'($random(seed));
            counter1_out_i <= 1'($random(seed));
            counter0_source_i <= 1'($random(seed));
            counter0_gate_i <= 1'($random(seed));
            digital_line_i <= 2'($random(seed));
            wait_cyc(8);
            src = j < 4 ? counter1_source_i : counter0_gate_i;
            check_sig("source mirror", src, function_pin_o[3]);
            check_sig("gate mirror", j < 4 ? counter1_gate_i : counter0_gate_i, function_pin_o[4]);
            check_sig("ctr1 out", counter1_out_i, counter1_output_o);
            check_sig("ctr0 src pin", counter0_source_i, function_pin_o[8]);
            if (j >= 4) check_sig("route ext", {3'h0, {2{counter0_gate_i}}, 3'h0}, route_ext_o);
            check_sig("direction", digital_line_i, {counter1_up_o, counter0_up_o});
        end
        check_sig("route sel", 8'h18, route_ext_sel_o);
        $display("test mirrors done");
        apb(OFF_PIN_DRIVE, 1, 0, 0, 0);
        repeat (2) begin
            ext_en <= 10'h3ff;
            ext_drive <= 10'($random(seed));
            wait_cyc(5);
            check_sig("oe off", 0, function_pin_oe_o);
            check_sig("analog trig", ext_drive[0], analog_trig_src_o);
            apb(OFF_PIN_STATUS, 0, 0, {11'h0, 1'b1, 2'h0, digital_line_i, 6'h0, ext_drive}, 0);
        end
        $display("test inputs done");
        wrap_up();
    end
endmodule : timing_signal_connector_pins_tb
